// File: src/bcm_pkg.sv
// Operation
// - each channel compares its 8-bit identifier against the page-entry-high identifier
// - identifier and mask control registers survive a manual reset
// - mask control bit 2 at 1 drops the identifier from the condition
// - mask selector: 00 full, 01 low 10 off, 10 low 12 off, 11 no address
// - mask control bits 7 to 3 read zero; software writes zero
// - channel B mask control has channel A layout and meaning
// - cycle condition registers clear on power-on and manual reset
// - cycle condition bits 15 to 6 are read-only zero
// - kind field: 00 none, 01 fetch, 10 data, 11 either
// - direction field: 00 none, 01 read, 10 write, 11 either
// - width field: 00 none, 01 byte, 10 word, 11 longword
// - channel B cycle condition uses channel A layout and codes
// - channel B has a 32-bit read/write data comparand
// - byte or word width ignores comparand bits 31 to 16
// - comparand ignored for fetch-kind setting or data compare off
// - data comparand survives a manual reset
// - match flag set on condition met, held until software writes 0 or either reset clears it
// - chained: flag B set only when B meets after A met
// - data compare on adds the data bus to channel B condition
// - fetch breaks taken before execution at 0, after at 1
package bcm_pkg;
	// ============================================================
	// register byte offsets
	localparam logic [7:0] BCM_OFS_ASID_A = 8'h00;
	localparam logic [7:0] BCM_OFS_ASID_B = 8'h04;
	localparam logic [7:0] BCM_OFS_AMASK_A = 8'h08;
	localparam logic [7:0] BCM_OFS_AMASK_B = 8'h0c;
	localparam logic [7:0] BCM_OFS_CYC_A = 8'h10;
	localparam logic [7:0] BCM_OFS_CYC_B = 8'h14;
	localparam logic [7:0] BCM_OFS_COMP_B = 8'h18;
	localparam logic [7:0] BCM_OFS_CTRL = 8'h1c;
	// ============================================================
	// field layout
	localparam int BCM_AMASK_IGN_ASID = 2;
	localparam logic [7:0] BCM_AMASK_WMASK = 8'h07;
	localparam logic [15:0] BCM_CYC_WMASK = 16'h003f;
	localparam logic [15:0] BCM_CYC_RESET = 16'h0000;
	localparam int BCM_CTRL_FLAG_A = 15;
	localparam int BCM_CTRL_FLAG_B = 14;
	localparam int BCM_CTRL_AFTER_A = 10;
	localparam int BCM_CTRL_DCMP_ON = 7;
	localparam int BCM_CTRL_AFTER_B = 6;
	localparam int BCM_CTRL_CHAIN = 3;
	localparam logic [15:0] BCM_CTRL_WMASK = 16'h04c8;
	localparam logic [15:0] BCM_CTRL_RESET = 16'h0000;
	localparam logic [31:0] BCM_LOW16 = 32'h0000_ffff;
	localparam logic [31:0] BCM_ALL32 = 32'hffff_ffff;
	localparam logic [31:0] BCM_LOW10 = 32'h0000_03ff;
	localparam logic [31:0] BCM_LOW12 = 32'h0000_0fff;
	localparam logic [1:0] BCM_RESP_OKAY = 2'h0;
	localparam logic [1:0] BCM_RESP_SLVERR = 2'h2;
	// ============================================================
	// field codes
	localparam logic [1:0] BCM_SEL_NONE = 2'h0;
	localparam logic [1:0] BCM_SEL_FIRST = 2'h1;
	localparam logic [1:0] BCM_SEL_SECOND = 2'h2;
	localparam logic [1:0] BCM_SEL_BOTH = 2'h3;
	localparam logic [1:0] BCM_SIZE_BYTE = 2'h1;
	localparam logic [1:0] BCM_SIZE_WORD = 2'h2;
	// observed bus cycle from the core
	typedef struct packed {
		logic valid;
		logic fetch;
		logic write;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] data;
	} bcm_cycle_t;
	// per-channel cycle condition fields
	typedef struct packed {
		logic [9:0] zero;
		logic [1:0] kind;
		logic [1:0] dir;
		logic [1:0] width;
	} bcm_cond_t;
endpackage

// File: src/bcm_break_match.sv
`timescale 1ns/1ps
module bcm_break_match (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic man_rst_i,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// observed core side
	input wire bcm_pkg::bcm_cycle_t cycle_i,
	input wire logic [7:0] page_entry_high_asid_i,
	input wire logic [31:0] break_address_a_i,
	input wire logic [31:0] break_address_b_i,
	input wire logic [31:0] data_mask_b_i,
	// results
	output logic match_a_o,
	output logic match_b_o,
	output logic break_after_a_o,
	output logic break_after_b_o,
	output logic match_flag_a_o,
	output logic match_flag_b_o
);
	// ============================================================
	// helpers
	// two-bit select against two qualifying conditions
	function automatic logic sel_ok(input logic [1:0] sel, input logic first,
		input logic second);
		case (sel)
			bcm_pkg::BCM_SEL_NONE: sel_ok = 1'b1;
			bcm_pkg::BCM_SEL_FIRST: sel_ok = first;
			bcm_pkg::BCM_SEL_SECOND: sel_ok = second;
			default: sel_ok = first | second;
		endcase
	endfunction

	// address compare under the mask selector
	function automatic logic addr_ok(input logic [1:0] sel, input logic [31:0] ref_a,
		input logic [31:0] obs);
		logic [31:0] keep;
		keep = bcm_pkg::BCM_ALL32;
		case (sel)
			bcm_pkg::BCM_SEL_NONE: keep = bcm_pkg::BCM_ALL32;
			bcm_pkg::BCM_SEL_FIRST: keep = ~bcm_pkg::BCM_LOW10;
			bcm_pkg::BCM_SEL_SECOND: keep = ~bcm_pkg::BCM_LOW12;
			default: keep = '0;
		endcase
		addr_ok = ((ref_a ^ obs) & keep) == '0;
	endfunction

	// full condition for one channel, data excluded
	function automatic logic chan_ok(input logic [7:0] amask, input logic [7:0] asid,
		input bcm_pkg::bcm_cond_t cond, input logic [31:0] baddr,
		input bcm_pkg::bcm_cycle_t cyc, input logic [7:0] obs_asid);
		logic asid_hit;
		asid_hit = amask[bcm_pkg::BCM_AMASK_IGN_ASID] || (asid == obs_asid);
		chan_ok = cyc.valid && asid_hit
			&& addr_ok(amask[1:0], baddr, cyc.addr)
			&& sel_ok(cond.kind, cyc.fetch, !cyc.fetch)
			&& sel_ok(cond.dir, !cyc.write, cyc.write)
			&& ((cond.width == bcm_pkg::BCM_SEL_NONE) || (cond.width == cyc.size));
	endfunction

	// ============================================================
	// registers
	logic [7:0] asid_a_q;
	logic [7:0] asid_b_q;
	logic [7:0] amask_a_q;
	logic [7:0] amask_b_q;
	bcm_pkg::bcm_cond_t cyc_a_q;
	bcm_pkg::bcm_cond_t cyc_b_q;
	logic [31:0] comp_b_q;
	logic [15:0] ctrl_q;
	logic [15:0] ctrl_d;
	logic flag_a_q;
	logic flag_b_q;
	logic aw_got_q;
	logic w_got_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic wr_fire;
	logic [31:0] cur_img;
	logic [31:0] wr_img;
	logic hit_a;
	logic hit_b;
	logic data_hit;
	logic set_b;
	logic match_a_q;
	logic match_b_q;
	logic after_a_q;
	logic after_b_q;

	// byte-lane merge of a write into a 32-bit image
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// ============================================================
	// axi write channel: aw and w accepted in any order
	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready = !w_got_q && !bvalid_q;
	assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_got_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_got_q <= 1'b0;
			end
		end
	end

	// write response, slverr on an unmapped word
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			bvalid_q <= 1'b0;
			bresp_q <= bcm_pkg::BCM_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= (awaddr_q > bcm_pkg::BCM_OFS_CTRL || awaddr_q[1:0] != 2'h0) ?
				bcm_pkg::BCM_RESP_SLVERR : bcm_pkg::BCM_RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ============================================================
	// word image of the addressed register, then merged with the write lanes;
	// one merge point keeps every register at its own width without slicing
	always_comb begin
		case (awaddr_q)
			bcm_pkg::BCM_OFS_ASID_A: cur_img = {24'h0, asid_a_q};
			bcm_pkg::BCM_OFS_ASID_B: cur_img = {24'h0, asid_b_q};
			bcm_pkg::BCM_OFS_AMASK_A: cur_img = {24'h0, amask_a_q};
			bcm_pkg::BCM_OFS_AMASK_B: cur_img = {24'h0, amask_b_q};
			bcm_pkg::BCM_OFS_CYC_A: cur_img = {16'h0, cyc_a_q};
			bcm_pkg::BCM_OFS_CYC_B: cur_img = {16'h0, cyc_b_q};
			bcm_pkg::BCM_OFS_COMP_B: cur_img = comp_b_q;
			bcm_pkg::BCM_OFS_CTRL: cur_img = {16'h0, flag_a_q, flag_b_q, ctrl_q[13:0]};
			default: cur_img = '0;
		endcase
	end
	assign wr_img = merge(cur_img, wdata_q, wstrb_q);

	// ============================================================
	// registers kept over a manual reset; power-on gives zero
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			asid_a_q <= '0;
			asid_b_q <= '0;
			amask_a_q <= '0;
			amask_b_q <= '0;
			comp_b_q <= '0;
		end else if (wr_fire) begin // man_rst_i not looked at here
			case (awaddr_q)
				bcm_pkg::BCM_OFS_ASID_A: asid_a_q <= wr_img[7:0];
				bcm_pkg::BCM_OFS_ASID_B: asid_b_q <= wr_img[7:0];
				bcm_pkg::BCM_OFS_AMASK_A: amask_a_q <= wr_img[7:0] & bcm_pkg::BCM_AMASK_WMASK;
				bcm_pkg::BCM_OFS_AMASK_B: amask_b_q <= wr_img[7:0] & bcm_pkg::BCM_AMASK_WMASK;
				bcm_pkg::BCM_OFS_COMP_B: comp_b_q <= wr_img;
				default: ;
			endcase
		end
	end

	// cycle conditions clear on either reset
	always_ff @(posedge clk_i) begin
		if (srst_i || man_rst_i) begin
			cyc_a_q <= bcm_pkg::BCM_CYC_RESET;
			cyc_b_q <= bcm_pkg::BCM_CYC_RESET;
		end else if (wr_fire && awaddr_q == bcm_pkg::BCM_OFS_CYC_A) begin
			cyc_a_q <= wr_img[15:0] & bcm_pkg::BCM_CYC_WMASK;
		end else if (wr_fire && awaddr_q == bcm_pkg::BCM_OFS_CYC_B) begin
			cyc_b_q <= wr_img[15:0] & bcm_pkg::BCM_CYC_WMASK;
		end
	end

	// control image: writable mode bits only; flags handled apart
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_fire && awaddr_q == bcm_pkg::BCM_OFS_CTRL) begin
			ctrl_d = wr_img[15:0] & bcm_pkg::BCM_CTRL_WMASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || man_rst_i) begin
			ctrl_q <= bcm_pkg::BCM_CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ============================================================
	// match logic
	// data compare: byte and word look only at the low half
	always_comb begin
		logic [31:0] keep;
		keep = ~data_mask_b_i;
		if (cyc_b_q.width == bcm_pkg::BCM_SIZE_BYTE || cyc_b_q.width == bcm_pkg::BCM_SIZE_WORD) begin
			keep = keep & bcm_pkg::BCM_LOW16;
		end
		data_hit = 1'b1;
		if (ctrl_q[bcm_pkg::BCM_CTRL_DCMP_ON] && cyc_b_q.kind != bcm_pkg::BCM_SEL_FIRST
			&& !cycle_i.fetch) begin
			data_hit = ((comp_b_q ^ cycle_i.data) & keep) == '0;
		end
	end

	assign hit_a = chan_ok(amask_a_q, asid_a_q, cyc_a_q, break_address_a_i, cycle_i,
		page_entry_high_asid_i);
	assign hit_b = chan_ok(amask_b_q, asid_b_q, cyc_b_q, break_address_b_i, cycle_i,
		page_entry_high_asid_i) && data_hit;
	// chained mode waits for a flag A left standing by an earlier cycle
	assign set_b = hit_b && (!ctrl_q[bcm_pkg::BCM_CTRL_CHAIN] || flag_a_q);

	// sticky flags: a set in the clearing cycle wins
	always_ff @(posedge clk_i) begin
		if (srst_i || man_rst_i) begin
			flag_a_q <= 1'b0;
			flag_b_q <= 1'b0;
		end else begin
			if (wr_fire && awaddr_q == bcm_pkg::BCM_OFS_CTRL && wstrb_q[1]) begin
				flag_a_q <= hit_a || (flag_a_q && wdata_q[bcm_pkg::BCM_CTRL_FLAG_A]);
				flag_b_q <= set_b || (flag_b_q && wdata_q[bcm_pkg::BCM_CTRL_FLAG_B]);
			end else begin
				flag_a_q <= flag_a_q || hit_a;
				flag_b_q <= flag_b_q || set_b;
			end
		end
	end

	// match pulses, with the before/after choice for fetch breaks
	always_ff @(posedge clk_i) begin
		if (srst_i || man_rst_i) begin
			match_a_q <= 1'b0;
			match_b_q <= 1'b0;
			after_a_q <= 1'b0;
			after_b_q <= 1'b0;
		end else begin
			match_a_q <= hit_a;
			match_b_q <= set_b;
			after_a_q <= hit_a && cycle_i.fetch && ctrl_q[bcm_pkg::BCM_CTRL_AFTER_A];
			after_b_q <= set_b && cycle_i.fetch && ctrl_q[bcm_pkg::BCM_CTRL_AFTER_B];
		end
	end

	assign match_a_o = match_a_q;
	assign match_b_o = match_b_q;
	assign break_after_a_o = after_a_q;
	assign break_after_b_o = after_b_q;
	assign match_flag_a_o = flag_a_q;
	assign match_flag_b_o = flag_b_q;

	// ============================================================
	// axi read channel, answer one cycle after the address
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= bcm_pkg::BCM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= bcm_pkg::BCM_RESP_OKAY;
			case (s_axi_araddr)
				bcm_pkg::BCM_OFS_ASID_A: rdata_q <= {24'h0, asid_a_q};
				bcm_pkg::BCM_OFS_ASID_B: rdata_q <= {24'h0, asid_b_q};
				bcm_pkg::BCM_OFS_AMASK_A: rdata_q <= {24'h0, amask_a_q};
				bcm_pkg::BCM_OFS_AMASK_B: rdata_q <= {24'h0, amask_b_q};
				bcm_pkg::BCM_OFS_CYC_A: rdata_q <= {16'h0, cyc_a_q};
				bcm_pkg::BCM_OFS_CYC_B: rdata_q <= {16'h0, cyc_b_q};
				bcm_pkg::BCM_OFS_COMP_B: rdata_q <= comp_b_q;
				bcm_pkg::BCM_OFS_CTRL: rdata_q <= {16'h0, flag_a_q, flag_b_q, ctrl_q[13:0]};
				default: begin
					rdata_q <= '0;
					rresp_q <= bcm_pkg::BCM_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ============================================================
	// checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	amask_zero_a: assert property (amask_a_q[7:3] == '0 && amask_b_q[7:3] == '0)
		else $error("mask control reserved bits set");
	cyc_zero_a: assert property (cyc_a_q.zero == '0 && cyc_b_q.zero == '0)
		else $error("cycle condition reserved bits set");
	man_clear_a: assert property (man_rst_i |=> cyc_a_q == '0 && cyc_b_q == '0 && !flag_b_q)
		else $error("manual reset left condition state");
	man_keep_a: assert property (man_rst_i && !wr_fire |=> $stable(comp_b_q) && $stable(asid_a_q))
		else $error("manual reset disturbed kept register");
	flag_set_a: assert property (hit_a && !man_rst_i |=> flag_a_q && match_a_o)
		else $error("flag a not set on match");
	flag_hold_a: assert property (flag_b_q && !man_rst_i && !wr_fire |=> flag_b_q)
		else $error("flag b dropped without clear");
	chain_order_a: assert property (ctrl_q[bcm_pkg::BCM_CTRL_CHAIN] && !flag_a_q && !flag_b_q
		&& !man_rst_i |=> !match_b_o)
		else $error("chained b fired before a");
	asid_gate_a: assert property (!amask_a_q[bcm_pkg::BCM_AMASK_IGN_ASID]
		&& asid_a_q != page_entry_high_asid_i
		|-> !hit_a)
		else $error("identifier mismatch still matched");
	addr_all_a: assert property (amask_a_q[1:0] == bcm_pkg::BCM_SEL_NONE
		&& break_address_a_i != cycle_i.addr |-> !hit_a)
		else $error("full address mismatch still matched");
	dcmp_off_a: assert property (!ctrl_q[bcm_pkg::BCM_CTRL_DCMP_ON] |-> data_hit)
		else $error("data compared while disabled");
	wr_resp_a: assert property (wr_fire |=> s_axi_bvalid)
		else $error("write response missing");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response missing");
	chain_c: cover property (ctrl_q[bcm_pkg::BCM_CTRL_CHAIN] && flag_a_q ##1 match_b_o);
	data_c: cover property (ctrl_q[bcm_pkg::BCM_CTRL_DCMP_ON] && hit_b);
	after_c: cover property (break_after_a_o);
	clear_c: cover property (flag_a_q ##1 !flag_a_q);
endmodule // bcm_break_match

// File: bench/bcm_core_model.sv
`timescale 1ns/1ps
// ============================================================
// core bus cycle and identifier source
module bcm_core_model (
	input wire logic clk_i,
	output bcm_pkg::bcm_cycle_t cycle_o,
	output logic [7:0] asid_o
);
	// quiet bus until the first cycle is issued
	initial begin
		cycle_o = '0;
		asid_o = 8'h00;
	end
	// one observed cycle lasting one clock; afterwards the released bus
	// shows the inverse so a stale copy can never pass for a match
	task automatic issue(input logic f, input logic w, input logic [1:0] s,
		input logic [31:0] a, input logic [31:0] d, input logic [7:0] id);
		@(posedge clk_i);
		cycle_o <= {1'b1, f, w, s, a, d};
		asid_o <= id;
		@(posedge clk_i);
		cycle_o <= {1'b0, ~f, ~w, ~s, ~a, ~d};
	endtask
endmodule // bcm_core_model

// File: bench/tb_break_condition_match.sv
`timescale 1ns/1ps
module tb_break_condition_match;
	// ============================================================
	// offsets, clock, drive and observe
	localparam logic [7:0] O_ASID = bcm_pkg::BCM_OFS_ASID_A;
	localparam logic [7:0] O_MSK = bcm_pkg::BCM_OFS_AMASK_A;
	localparam logic [7:0] O_CYC = bcm_pkg::BCM_OFS_CYC_A;
	localparam logic [7:0] O_CMP = bcm_pkg::BCM_OFS_COMP_B;
	localparam logic [7:0] O_CTL = bcm_pkg::BCM_OFS_CTRL;
	localparam logic [31:0] BA = 32'h8000_1000;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic man_rst_i = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, dmask = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, ma, mb, aa, ab, fa, fb;
	logic [1:0] bresp, rresp, resp;
	logic [3:0] wstrb = 4'hf;
	logic [31:0] offs [3] = '{32'h200, 32'h800, 32'h1000};
	bcm_pkg::bcm_cycle_t cyc;
	logic [7:0] asid;
	int fails = 0;
	int comparisons = 0;
	logic [15:0] cond;
	logic [31:0] v;
	// free-running clock, 10 ns
	always #5 clk_i = ~clk_i;
	bcm_core_model u_core (.clk_i(clk_i), .cycle_o(cyc), .asid_o(asid));
	bcm_break_match u_dut (
		.clk_i(clk_i), .srst_i(srst_i), .man_rst_i(man_rst_i),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .cycle_i(cyc),
		.page_entry_high_asid_i(asid), .break_address_a_i(BA), .break_address_b_i(BA),
		.data_mask_b_i(dmask), .match_a_o(ma), .match_b_o(mb), .break_after_a_o(aa),
		.break_after_b_o(ab), .match_flag_a_o(fa), .match_flag_b_o(fb)
	);
	// ============================================================
	// checking and closing
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ============================================================
	// register bus master; ready sampled at the falling edge, which
	// shows what the next rising edge will see without a race
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_t, w_t, b_t;
		b_t = 1'b0;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 40 && !b_t; n++) begin
			@(negedge clk_i);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid;
			resp = bresp;
			@(posedge clk_i);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			if (b_t) bready <= 1'b0;
		end
		if (!b_t) begin
			fails++;
			conclude();
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic ar_t, r_t;
		r_t = 1'b0;
		d = '0;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 40 && !r_t; n++) begin
			@(negedge clk_i);
			ar_t = arvalid && arready;
			r_t = rvalid;
			d = rdata;
			resp = rresp;
			@(posedge clk_i);
			if (ar_t) arvalid <= 1'b0;
			if (r_t) rready <= 1'b0;
		end
		if (!r_t) begin
			fails++;
			conclude();
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk($sformatf("reg %h", a), d, e);
	endtask
	// same value to channel a and its channel b twin four bytes on
	task automatic wab(input logic [7:0] a, input logic [31:0] d);
		wr(a, d);
		wr(a + 8'h04, d);
	endtask
	// one core cycle, then match and after pulses of both channels
	task automatic hit(input logic f, input logic w, input logic [1:0] s,
		input logic [31:0] a, input logic [31:0] d, input logic [7:0] id, input logic [3:0] e);
		u_core.issue(f, w, s, a, d, id);
		#1;
		chk("match a b after a b", {28'h0, ma, mb, aa, ab}, {28'h0, e});
	endtask
	// ============================================================
	// main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		rc(O_CYC, 32'h0);
		rc(O_CYC + 8'h04, 32'h0);
		// reserved bits stay zero even when written with ones
		wab(O_MSK, 32'hffff_ffff);
		rc(O_MSK, 32'h07);
		rc(O_MSK + 8'h04, 32'h07);
		wab(O_CYC, 32'hffff_ffff);
		rc(O_CYC, 32'h3f);
		rc(O_CYC + 8'h04, 32'h3f);
		wr(O_CMP, 32'ha5c3_0f69);
		rc(O_CMP, 32'ha5c3_0f69);
		rd(8'h20, v);
		chk("unmapped read", {30'h0, resp}, {30'h0, bcm_pkg::BCM_RESP_SLVERR});
		wr(8'h20, 32'h1);
		chk("unmapped write", {30'h0, resp}, {30'h0, bcm_pkg::BCM_RESP_SLVERR});
		// identifier compare and ignore
		wab(O_ASID, 32'h5a);
		wab(O_CYC, 32'h3c);
		wab(O_MSK, 32'h00);
		hit(1'b0, 1'b0, 2'h3, BA, 32'h0, 8'h5a, 4'b1100);
		hit(1'b0, 1'b0, 2'h3, BA, 32'h0, 8'h5b, 4'b0000);
		wab(O_MSK, 32'h04);
		hit(1'b0, 1'b0, 2'h3, BA, 32'h0, 8'h5b, 4'b1100);
		// address mask selector against a flipped bit 9, 11 or 12
		for (int s = 0; s < 4; s++) begin
			wab(O_MSK, 32'h4 | s);
			for (int k = 0; k < 3; k++) begin
				hit(1'b0, 1'b0, 2'h3, BA ^ offs[k], 32'h0, 8'h5a, {{2{s > k}}, 2'b00});
			end
		end
		// every code of kind, direction and width, two probes each
		for (int f = 0; f < 3; f++) begin
			for (int c = 0; c < 4; c++) begin
				cond = 16'((f == 0) ? 16'h0c | (c << 4) :
					(f == 1) ? 16'h30 | (c << 2) : 16'h3c | c);
				wab(O_CYC, {16'h0, cond});
				for (int p = 1; p < 3; p++) begin
					hit(f == 0 && p == 1, f == 1 && p == 2, (f == 2) ? p[1:0] : 2'h3, BA, 32'h0,
						8'h5a, {{2{c == 0 || c == p || (f < 2 && c == 3)}}, 2'b00});
				end
			end
		end
		// break before or after execution of a fetch
		wr(O_CTL, 32'h0440);
		wab(O_CYC, 32'h10);
		hit(1'b1, 1'b0, 2'h3, BA, 32'h0, 8'h5a, 4'b1111);
		wr(O_CTL, 32'h0);
		hit(1'b1, 1'b0, 2'h3, BA, 32'h0, 8'h5a, 4'b1100);
		// sticky flags cleared only by writing zero
		rc(O_CTL, 32'hc000);
		wr(O_CTL, 32'hc000);
		rc(O_CTL, 32'hc000);
		wr(O_CTL, 32'h0);
		rc(O_CTL, 32'h0);
		// channel b data comparand, word then longword then byte
		wr(O_CTL, 32'h80);
		wr(O_CYC + 8'h04, 32'h22);
		wr(O_CMP, 32'hdead_1234);
		hit(1'b0, 1'b0, 2'h2, BA, 32'h0000_1234, 8'h5a, 4'b0100);
		hit(1'b0, 1'b0, 2'h2, BA, 32'h0000_1230, 8'h5a, 4'b0000);
		@(posedge clk_i);
		dmask <= 32'h0000_000f;
		hit(1'b0, 1'b0, 2'h2, BA, 32'h0000_1230, 8'h5a, 4'b0100);
		@(posedge clk_i);
		dmask <= 32'h0;
		wr(O_CYC + 8'h04, 32'h23);
		hit(1'b0, 1'b0, 2'h3, BA, 32'h0000_1234, 8'h5a, 4'b0000);
		wr(O_CYC + 8'h04, 32'h21);
		wr(O_CMP, 32'h0000_3434);
		hit(1'b0, 1'b0, 2'h1, BA, 32'h0000_3434, 8'h5a, 4'b0100);
		wr(O_CTL, 32'h0);
		wr(O_CYC + 8'h04, 32'h22);
		hit(1'b0, 1'b0, 2'h2, BA, 32'h0000_0099, 8'h5a, 4'b0100);
		wr(O_CTL, 32'h80);
		wr(O_CYC + 8'h04, 32'h10);
		hit(1'b1, 1'b0, 2'h3, BA, 32'h0000_0099, 8'h5a, 4'b1100);
		// chained channels: b alone refused, a then b accepted
		wr(O_CTL, 32'h08);
		wr(O_CYC + 8'h04, 32'h20);
		hit(1'b0, 1'b0, 2'h3, BA, 32'h0, 8'h5a, 4'b0000);
		chk("flag b", {31'h0, fb}, 32'h0);
		hit(1'b1, 1'b0, 2'h3, BA, 32'h0, 8'h5a, 4'b1000);
		hit(1'b0, 1'b0, 2'h3, BA, 32'h0, 8'h5a, 4'b0100);
		chk("flags", {30'h0, fa, fb}, 32'h3);
		// a control write that skips the flag lane leaves both flags standing
		@(posedge clk_i);
		wstrb <= 4'h1;
		wr(O_CTL, 32'h0008);
		rc(O_CTL, 32'hc008);
		@(posedge clk_i);
		wstrb <= 4'hf;
		// manual reset keeps identifiers, masks and comparand
		@(posedge clk_i);
		man_rst_i <= 1'b1;
		@(posedge clk_i);
		man_rst_i <= 1'b0;
		rc(O_ASID, 32'h5a);
		rc(O_MSK, 32'h07);
		rc(O_CMP, 32'h0000_3434);
		rc(O_CYC, 32'h0);
		rc(O_CTL, 32'h0);
		conclude();
	end
endmodule // tb_break_condition_match
